// ### pkg/fcsr_map.vh
`ifndef FCSR_MAP_VH
`define FCSR_MAP_VH

// ============================================================
// Command and response packet type codes
`define FCSR_CMD_PART_STATS   8'h2F
`define FCSR_CMD_FC_LINK      8'h31
`define FCSR_RSP_PART_STATS   8'hAF
`define FCSR_RSP_FC_LINK      8'hB1
`define FCSR_STATS_TYPE_FC    8'h03

// ============================================================
// Response and reason codes
`define FCSR_RSP_CODE_OK      16'h0000
`define FCSR_RSP_CODE_FAIL    16'h0001
`define FCSR_RSN_NONE         16'h0000
`define FCSR_RSN_PHY_ACCESS   16'h800C

// ============================================================
// Word positions inside a response (word n covers bytes 4n to 4n+3)
`define FCSR_W_CODES          4'h4
`define FCSR_W_FIELDS         4'h5
`define FCSR_W_CTR_FIRST      4'h6
`define FCSR_W_STATS_LAST     4'hE
`define FCSR_W_LINK_LAST      4'h5
`define FCSR_NUM_CTRS         9

// ============================================================
// Counter positions in the cleared-flags field, in response order
`define FCSR_CTR_RX_FRAMES    0
`define FCSR_CTR_TX_FRAMES    1
`define FCSR_CTR_RX_KB        2
`define FCSR_CTR_TX_KB        3
`define FCSR_CTR_RX_SEQ       4
`define FCSR_CTR_TX_SEQ       5
`define FCSR_CTR_LINK_FAIL    6
`define FCSR_CTR_SIG_LOSS     7
`define FCSR_CTR_BAD_CRC      8

// ============================================================
// Link status fields and driver state codes
`define FCSR_LINK_UP_BIT      0
`define FCSR_DRV_RESERVED     2'h3
`define FCSR_DRV_NOT_IMPL     2'h0

// ============================================================
// Timing
`define FCSR_CLK_NS           8
`define FCSR_PHY_TMO_NS       2000

`endif

// ### src/fcsr_pin_sync.v
`timescale 1ns/1ps
`include "fcsr_map.vh"

module fcsr_pin_sync
(
  // Clock and reset
  input  wire clk_i,
  input  wire rst_b_i,
  // Asynchronous pin level
  input  wire pin_i,
  // Filtered level and its rising edge
  output wire level_o,
  output wire rise_o
);

  reg s1_q;
  reg s2_q;
  reg s3_q;
  reg level_q;
  reg rise_q;

  // ============================================================
  // Three stages; the level only moves once stages two and three agree.
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      level_q <= 1'b0;
      rise_q  <= 1'b0;
    end
    else
    begin
      s1_q    <= pin_i;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      rise_q  <= (s2_q == s3_q) && s3_q && !level_q;
      if (s2_q == s3_q)
      begin
        level_q <= s3_q;
      end
    end
  end

  assign level_o = level_q;
  assign rise_o  = rise_q;

endmodule

// ### src/fcsr_event_ctr.v
`timescale 1ns/1ps
`include "fcsr_map.vh"

module fcsr_event_ctr
(
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_b_i,
  // Event, clear and report strobes
  input  wire        inc_i,
  input  wire        clr_i,
  input  wire        rd_i,
  // Count and cleared-since-read flag
  output wire [31:0] count_o,
  output wire        cleared_o
);

  reg [31:0] count_q;
  reg        cleared_q;

  // ============================================================
  // A clear beats a coincident event; the count wraps at full scale.
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      count_q   <= 32'h0000_0000;
      cleared_q <= 1'b0;
    end
    else
    begin
      if (clr_i)
      begin
        count_q <= 32'h0000_0000;
      end
      else if (inc_i)
      begin
        count_q <= count_q + 32'h0000_0001;
      end
      // A clear arriving with the report keeps the flag set.
      if (clr_i)
      begin
        cleared_q <= 1'b1;
      end
      else if (rd_i)
      begin
        cleared_q <= 1'b0;
      end
    end
  end

  assign count_o   = count_q;
  assign cleared_o = cleared_q;

endmodule

// ### src/fcsr_responder.v
`timescale 1ns/1ps
`include "fcsr_map.vh"

module fcsr_responder
(
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_b_i,
  // Parsed command from the packet front end
  input  wire        cmd_valid_i,
  output wire        cmd_ready_o,
  input  wire [7:0]  cmd_code_i,
  input  wire [7:0]  cmd_stats_type_i,
  input  wire        cmd_chk_err_i,
  input  wire        cmd_id_err_i,
  output wire        cmd_drop_o,
  // Response payload words towards header and checksum logic
  output wire        rsp_valid_o,
  input  wire        rsp_ready_i,
  output wire [7:0]  rsp_pkt_type_o,
  output wire [3:0]  rsp_word_idx_o,
  output wire [31:0] rsp_word_o,
  output wire        rsp_last_o,
  // Traffic events from port logic, one-cycle pulses
  input  wire        ev_rx_frame_i,
  input  wire        ev_tx_frame_i,
  input  wire        ev_rx_kb_i,
  input  wire        ev_tx_kb_i,
  input  wire        ev_rx_seq_i,
  input  wire        ev_tx_seq_i,
  input  wire        ev_crc_err_i,
  // Fault indications from pins
  input  wire        link_fail_pin_i,
  input  wire        sig_loss_pin_i,
  // Counter clear strobes, one bit per counter in response order
  input  wire [8:0]  ctr_clr_i,
  // PHY access for link status
  output wire        phy_rd_o,
  input  wire        phy_done_i,
  input  wire        phy_fail_i,
  input  wire        phy_link_up_i,
  input  wire [2:0]  phy_speed_i,
  // Configuration and host driver state
  input  wire        cfg_fc_native_i,
  input  wire [1:0]  drv_state_i
);

  // ============================================================
  // States and timing
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_PHYW = 4'b0010;
  localparam [3:0] ST_LOAD = 4'b0100;
  localparam [3:0] ST_SEND = 4'b1000;

  // A PHY that never answers is treated as a failed access.
  localparam integer TMO_INT = `FCSR_PHY_TMO_NS / `FCSR_CLK_NS;
  localparam [8:0]   TMO_CYC = TMO_INT[8:0];

  // ============================================================
  // Declarations
  reg  [3:0]  state_q;
  reg  [7:0]  pkt_type_q;
  reg  [15:0] rsp_code_q;
  reg  [15:0] reason_q;
  reg  [3:0]  last_idx_q;
  reg  [3:0]  idx_q;
  reg  [31:0] word_q;
  reg         valid_q;
  reg         drop_q;
  reg         phy_rd_q;
  reg  [8:0]  tmo_q;
  reg  [7:0]  link_byte_q;
  reg  [7:0]  drv_byte_q;
  reg  [8:0]  flags_q;
  reg  [31:0] snap_q [0:8];

  wire        lf_rise;
  wire        los_rise;
  wire [8:0]  ev_vec;
  wire [287:0] cnt_w;
  wire [8:0]  clrd_w;
  wire        take;
  wire        chk_ok;
  wire        is_stats;
  wire        is_link;
  wire        adv;
  wire        rd_now;

  integer     i;

  // ============================================================
  // Pin conditioning for the two fault inputs
  fcsr_pin_sync u_lf_sync
  (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .pin_i   (link_fail_pin_i),
    .level_o (),
    .rise_o  (lf_rise)
  );

  fcsr_pin_sync u_los_sync
  (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .pin_i   (sig_loss_pin_i),
    .level_o (),
    .rise_o  (los_rise)
  );

  // ============================================================
  // Counter bank, indexed in response order
  assign ev_vec[`FCSR_CTR_RX_FRAMES] = ev_rx_frame_i;
  assign ev_vec[`FCSR_CTR_TX_FRAMES] = ev_tx_frame_i;
  assign ev_vec[`FCSR_CTR_RX_KB]     = ev_rx_kb_i;
  assign ev_vec[`FCSR_CTR_TX_KB]     = ev_tx_kb_i;
  assign ev_vec[`FCSR_CTR_RX_SEQ]    = ev_rx_seq_i;
  assign ev_vec[`FCSR_CTR_TX_SEQ]    = ev_tx_seq_i;
  assign ev_vec[`FCSR_CTR_LINK_FAIL] = lf_rise;
  assign ev_vec[`FCSR_CTR_SIG_LOSS]  = los_rise;
  assign ev_vec[`FCSR_CTR_BAD_CRC]   = ev_crc_err_i;

  genvar g;
  generate
    for (g = 0; g < `FCSR_NUM_CTRS; g = g + 1)
    begin : g_ctr
      fcsr_event_ctr u_ctr
      (
        .clk_i     (clk_i),
        .rst_b_i   (rst_b_i),
        .inc_i     (ev_vec[g]),
        .clr_i     (ctr_clr_i[g]),
        .rd_i      (rd_now),
        .count_o   (cnt_w[g*32 +: 32]),
        .cleared_o (clrd_w[g])
      );
    end
  endgenerate

  // ============================================================
  // Command decode
  assign take     = cmd_valid_i && (state_q == ST_IDLE);
  assign chk_ok   = !cmd_chk_err_i && !cmd_id_err_i;
  assign is_stats = (cmd_code_i == `FCSR_CMD_PART_STATS) &&
                    (cmd_stats_type_i == `FCSR_STATS_TYPE_FC);
  assign is_link  = (cmd_code_i == `FCSR_CMD_FC_LINK) && cfg_fc_native_i;
  assign adv      = valid_q && rsp_ready_i;
  // Flags drop on the snapshot edge itself, so a clear landing on that edge survives.
  assign rd_now   = take && chk_ok && is_stats;

  // ============================================================
  // Field packing
  function [7:0] fcsr_link_byte;
    input       up;
    input [2:0] speed;
    begin
      fcsr_link_byte = {3'b000, 1'b0, speed, up};
    end
  endfunction

  function [7:0] fcsr_drv_byte;
    input [1:0] st;
    begin
      // The reserved code is never reported; it reads as not implemented.
      if (st == `FCSR_DRV_RESERVED)
      begin
        fcsr_drv_byte = {6'b000000, `FCSR_DRV_NOT_IMPL};
      end
      else
      begin
        fcsr_drv_byte = {6'b000000, st};
      end
    end
  endfunction

  // Byte 4n of the packet sits in bits 31:24 of word n.
  function [31:0] fcsr_word;
    input [3:0] idx;
    reg   [3:0] ci;
    begin
      ci = idx - `FCSR_W_CTR_FIRST;
      if (idx == `FCSR_W_CODES)
      begin
        fcsr_word = {rsp_code_q, reason_q};
      end
      else if (idx == `FCSR_W_FIELDS && pkt_type_q == `FCSR_RSP_PART_STATS)
      begin
        fcsr_word = {16'h0000, 7'h00, flags_q};
      end
      else if (idx == `FCSR_W_FIELDS)
      begin
        fcsr_word = {16'h0000, drv_byte_q, link_byte_q};
      end
      else if (idx <= `FCSR_W_STATS_LAST)
      begin
        fcsr_word = snap_q[ci];
      end
      else
      begin
        fcsr_word = 32'h0000_0000;
      end
    end
  endfunction

  // ============================================================
  // Snapshot of counters and flags, taken when a stats query is accepted
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      for (i = 0; i < `FCSR_NUM_CTRS; i = i + 1)
      begin
        snap_q[i] <= 32'h0000_0000;
      end
      flags_q <= 9'h000;
    end
    else
    begin
      // Freezing all nine at once keeps the response self-consistent.
      if (take && chk_ok && is_stats)
      begin
        for (i = 0; i < `FCSR_NUM_CTRS; i = i + 1)
        begin
          snap_q[i] <= cnt_w[i*32 +: 32];
        end
        flags_q <= clrd_w;
      end
    end
  end

  // ============================================================
  // Sequencer
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_q     <= ST_IDLE;
      pkt_type_q  <= 8'h00;
      rsp_code_q  <= `FCSR_RSP_CODE_OK;
      reason_q    <= `FCSR_RSN_NONE;
      last_idx_q  <= `FCSR_W_CODES;
      idx_q       <= `FCSR_W_CODES;
      word_q      <= 32'h0000_0000;
      valid_q     <= 1'b0;
      drop_q      <= 1'b0;
      phy_rd_q    <= 1'b0;
      tmo_q       <= 9'h000;
      link_byte_q <= 8'h00;
      drv_byte_q  <= 8'h00;
    end
    else
    begin
      drop_q   <= 1'b0;
      phy_rd_q <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          if (take && chk_ok && is_stats)
          begin
            pkt_type_q <= `FCSR_RSP_PART_STATS;
            rsp_code_q <= `FCSR_RSP_CODE_OK;
            reason_q   <= `FCSR_RSN_NONE;
            last_idx_q <= `FCSR_W_STATS_LAST;
            state_q    <= ST_LOAD;
          end
          else if (take && chk_ok && is_link)
          begin
            pkt_type_q <= `FCSR_RSP_FC_LINK;
            last_idx_q <= `FCSR_W_LINK_LAST;
            phy_rd_q   <= 1'b1;
            tmo_q      <= 9'h000;
            state_q    <= ST_PHYW;
          end
          else if (take)
          begin
            // Bad checksum, wrong identifier or a query this block does not serve.
            drop_q <= 1'b1;
          end
        end
        ST_PHYW:
        begin
          if (phy_done_i && !phy_fail_i)
          begin
            rsp_code_q  <= `FCSR_RSP_CODE_OK;
            reason_q    <= `FCSR_RSN_NONE;
            link_byte_q <= fcsr_link_byte(phy_link_up_i, phy_speed_i);
            drv_byte_q  <= fcsr_drv_byte(drv_state_i);
            state_q     <= ST_LOAD;
          end
          else if (phy_done_i || tmo_q == TMO_CYC)
          begin
            // The response still goes out, carrying the access failure.
            rsp_code_q  <= `FCSR_RSP_CODE_FAIL;
            reason_q    <= `FCSR_RSN_PHY_ACCESS;
            link_byte_q <= 8'h00;
            drv_byte_q  <= 8'h00;
            state_q     <= ST_LOAD;
          end
          else
          begin
            tmo_q <= tmo_q + 9'h001;
          end
        end
        ST_LOAD:
        begin
          idx_q   <= `FCSR_W_CODES;
          word_q  <= fcsr_word(`FCSR_W_CODES);
          valid_q <= 1'b1;
          state_q <= ST_SEND;
        end
        ST_SEND:
        begin
          if (adv && idx_q == last_idx_q)
          begin
            valid_q <= 1'b0;
            state_q <= ST_IDLE;
          end
          else if (adv)
          begin
            idx_q  <= idx_q + 4'h1;
            word_q <= fcsr_word(idx_q + 4'h1);
          end
        end
        default:
        begin
          valid_q <= 1'b0;
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ============================================================
  // Outputs
  assign cmd_ready_o    = (state_q == ST_IDLE);
  assign cmd_drop_o     = drop_q;
  assign rsp_valid_o    = valid_q;
  assign rsp_pkt_type_o = pkt_type_q;
  assign rsp_word_idx_o = idx_q;
  assign rsp_word_o     = word_q;
  assign rsp_last_o     = valid_q && (idx_q == last_idx_q);
  assign phy_rd_o       = phy_rd_q;

endmodule

// ### verification/fcsr_responder_chk.sv
`timescale 1ns/1ps
`include "fcsr_map.vh"

// ====================
// Port checker
module fcsr_responder_chk
(
  // Command side
  input logic        clk_i,
  input logic        rst_b_i,
  input logic        cmd_valid_i,
  input logic        cmd_ready_o,
  input logic [7:0]  cmd_code_i,
  input logic [7:0]  cmd_stats_type_i,
  input logic        cmd_chk_err_i,
  input logic        cmd_id_err_i,
  input logic        cmd_drop_o,
  // Response side
  input logic        rsp_valid_o,
  input logic        rsp_ready_i,
  input logic [7:0]  rsp_pkt_type_o,
  input logic [3:0]  rsp_word_idx_o,
  input logic [31:0] rsp_word_o,
  input logic        rsp_last_o,
  // PHY side and state
  input logic        phy_rd_o,
  input logic        phy_done_i,
  input logic        phy_fail_i,
  input logic        phy_link_up_i,
  input logic [2:0]  phy_speed_i,
  input logic        cfg_fc_native_i,
  input logic [1:0]  drv_state_i
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  wire         take = cmd_valid_i && cmd_ready_o;
  wire         ok   = !cmd_chk_err_i && !cmd_id_err_i;
  wire         lnk  = rsp_valid_o && rsp_pkt_type_o == `FCSR_RSP_FC_LINK;
  wire         sts  = rsp_valid_o && rsp_pkt_type_o == `FCSR_RSP_PART_STATS;
  logic        fail_q;
  logic [31:0] link_q;

  // An access that never completes must still end as a failure.
  always @(posedge clk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      fail_q <= 1'h0;
      link_q <= 32'h0;
    end
    else if (phy_rd_o)
      fail_q <= 1'h1;
    else if (phy_done_i)
    begin
      fail_q <= phy_fail_i;
      link_q <= {22'h0, (drv_state_i == 2'h3) ? 2'h0 : drv_state_i, 4'h0, phy_speed_i,
                 phy_link_up_i};
    end

  a_stats_accept: assert property (
    take && ok && cmd_code_i == `FCSR_CMD_PART_STATS && cmd_stats_type_i == `FCSR_STATS_TYPE_FC
    |-> ##2 sts && rsp_word_idx_o == 4'h4 && rsp_word_o == 32'h0)
    else $error("stats query not answered");
  a_error_drop: assert property (
    take && !ok |=> cmd_drop_o && !phy_rd_o ##1 !rsp_valid_o [*3])
    else $error("bad command not dropped");
  a_link_start: assert property (
    take && ok && cmd_code_i == `FCSR_CMD_FC_LINK && cfg_fc_native_i |=> phy_rd_o && !cmd_drop_o)
    else $error("link query did not start access");
  a_link_native: assert property (
    take && ok && cmd_code_i == `FCSR_CMD_FC_LINK && !cfg_fc_native_i |=> cmd_drop_o && !phy_rd_o)
    else $error("link query on non native channel");
  a_link_answer: assert property (
    phy_done_i |-> ##2 lnk && rsp_word_idx_o == 4'h4)
    else $error("link response late");
  a_link_reason: assert property (
    lnk && rsp_word_idx_o == 4'h4
    |-> rsp_word_o == (fail_q ? {`FCSR_RSP_CODE_FAIL, `FCSR_RSN_PHY_ACCESS} : 32'h0))
    else $error("link codes wrong");
  a_link_fields: assert property (
    lnk && rsp_word_idx_o == 4'h5 |-> rsp_last_o && rsp_word_o == (fail_q ? 32'h0 : link_q))
    else $error("link status word wrong");
  a_word_order: assert property (
    rsp_valid_o && rsp_ready_i && !rsp_last_o
    |=> rsp_valid_o && rsp_word_idx_o == $past(rsp_word_idx_o) + 4'h1)
    else $error("word index did not step");
  a_stats_last: assert property (
    sts |-> rsp_last_o == (rsp_word_idx_o == `FCSR_W_STATS_LAST))
    else $error("stats last word wrong");
  a_flags_resvd: assert property (
    sts && rsp_word_idx_o == 4'h5 |-> rsp_word_o[31:9] == 23'h0)
    else $error("reserved flag bits set");
  a_word_hold: assert property (
    rsp_valid_o && !rsp_ready_i |=> rsp_valid_o && $stable(rsp_word_o) && $stable(rsp_word_idx_o))
    else $error("word changed while stalled");

  c_stats: cover property (sts && rsp_last_o && rsp_ready_i);
  c_drop: cover property (cmd_drop_o);
  c_fail: cover property (lnk && fail_q && rsp_last_o);
endmodule

bind fcsr_responder fcsr_responder_chk i_chk
(
  .clk_i, .rst_b_i, .cmd_valid_i, .cmd_ready_o, .cmd_code_i, .cmd_stats_type_i,
  .cmd_chk_err_i, .cmd_id_err_i, .cmd_drop_o, .rsp_valid_o, .rsp_ready_i, .rsp_pkt_type_o,
  .rsp_word_idx_o, .rsp_word_o, .rsp_last_o, .phy_rd_o, .phy_done_i, .phy_fail_i,
  .phy_link_up_i, .phy_speed_i, .cfg_fc_native_i, .drv_state_i
);

// ### verification/fcsr_phy_model.sv
`timescale 1ns/1ps

// ====================
// PHY access responder
module fcsr_phy_model
(
  // Clock and reset
  input  logic       clk_i,
  input  logic       rst_b_i,
  // Access request and scenario controls
  input  logic       rd_i,
  input  logic [7:0] dly_i,
  input  logic       fail_i,
  input  logic       mute_i,
  input  logic       up_i,
  input  logic [2:0] spd_i,
  // Completion towards the responder
  output logic       done_o,
  output logic       fail_o,
  output logic       link_up_o,
  output logic [2:0] speed_o
);
  logic       busy_q;
  logic [7:0] cnt_q;
  logic       up_q;
  logic [2:0] spd_q;

  always @(posedge clk_i or negedge rst_b_i)
    if (!rst_b_i)
      {busy_q, cnt_q, up_q, spd_q, done_o, fail_o} <= 15'h0;
    else
    begin
      done_o <= 1'h0;
      fail_o <= 1'h0;
      if (rd_i && !mute_i)
      begin
        busy_q <= 1'h1;
        cnt_q  <= dly_i;
      end
      else if (busy_q && cnt_q != 8'h00)
        cnt_q <= cnt_q - 8'h01;
      else if (busy_q)
      begin
        busy_q <= 1'h0;
        done_o <= 1'h1;
        fail_o <= fail_i;
        up_q   <= up_i;
        spd_q  <= spd_i;
      end
    end

  // Status carries nothing valid outside the done cycle, so show the inverse there.
  assign link_up_o = done_o ? up_q : ~up_q;
  assign speed_o   = done_o ? spd_q : ~spd_q;
endmodule

// ### verification/fcsr_responder_tb.sv
`timescale 1ns/1ps
`include "fcsr_map.vh"

// ====================
// Bench
module fcsr_responder_tb;
  logic        clk_i = 1'h0;
  logic        rst_b_i = 1'h0;
  logic        cmd_valid_i = 1'h0;
  logic        cmd_chk_err_i = 1'h0;
  logic        cmd_id_err_i = 1'h0;
  logic        rsp_ready_i = 1'h0;
  logic        cfg_fc_native_i = 1'h1;
  logic [7:0]  cmd_code_i = 8'h00;
  logic [7:0]  cmd_stats_type_i = 8'h00;
  logic [6:0]  ev = 7'h00;
  logic [1:0]  pin = 2'h0;
  logic [8:0]  ctr_clr_i = 9'h000;
  logic [1:0]  drv_state_i = 2'h0;
  logic [7:0]  p_dly = 8'h00;
  logic        p_fail = 1'h0;
  logic        p_mute = 1'h0;
  logic        p_up = 1'h0;
  logic [2:0]  p_spd = 3'h0;
  logic [31:0] seed = 32'h0000FC8A;
  logic [31:0] cnt [0:8];
  logic [31:0] ew [4:14];
  logic [8:0]  flg = 9'h000;
  int          failures = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          k;
  wire         cmd_ready_o, cmd_drop_o, rsp_valid_o, rsp_last_o, phy_rd_o;
  wire         phy_done_i, phy_fail_i, phy_link_up_i;
  wire [7:0]   rsp_pkt_type_o;
  wire [3:0]   rsp_word_idx_o;
  wire [31:0]  rsp_word_o;
  wire [2:0]   phy_speed_i;

  always #4 clk_i = ~clk_i;

  fcsr_responder i_dut
  (
    .clk_i, .rst_b_i, .cmd_valid_i, .cmd_ready_o, .cmd_code_i, .cmd_stats_type_i,
    .cmd_chk_err_i, .cmd_id_err_i, .cmd_drop_o, .rsp_valid_o, .rsp_ready_i, .rsp_pkt_type_o,
    .rsp_word_idx_o, .rsp_word_o, .rsp_last_o, .ev_rx_frame_i(ev[0]), .ev_tx_frame_i(ev[1]),
    .ev_rx_kb_i(ev[2]), .ev_tx_kb_i(ev[3]), .ev_rx_seq_i(ev[4]), .ev_tx_seq_i(ev[5]),
    .ev_crc_err_i(ev[6]), .link_fail_pin_i(pin[0]), .sig_loss_pin_i(pin[1]), .ctr_clr_i,
    .phy_rd_o, .phy_done_i, .phy_fail_i, .phy_link_up_i, .phy_speed_i, .cfg_fc_native_i,
    .drv_state_i
  );

  fcsr_phy_model i_phy
  (
    .clk_i, .rst_b_i, .rd_i(phy_rd_o), .dly_i(p_dly), .fail_i(p_fail), .mute_i(p_mute),
    .up_i(p_up), .spd_i(p_spd), .done_o(phy_done_i), .fail_o(phy_fail_i),
    .link_up_o(phy_link_up_i), .speed_o(phy_speed_i)
  );

  function automatic logic [31:0] nxt();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] link_w(input logic u, input logic [2:0] s, input logic [1:0] d);
    return {22'h0, (d == 2'h3) ? 2'h0 : d, 4'h0, s, u};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic send_cmd(input logic [7:0] c, input logic [7:0] t, input logic e1, input logic e2);
    int g;
    g = 0;
    @(negedge clk_i);
    {cmd_valid_i, cmd_code_i, cmd_stats_type_i, cmd_chk_err_i, cmd_id_err_i} = {1'h1, c, t, e1, e2};
    while (cmd_ready_o !== 1'h1 && g < 400)
    begin
      @(negedge clk_i);
      g++;
    end
    @(negedge clk_i);
    cmd_valid_i = 1'h0;
  endtask

  // Ready is thrown at random, high three cycles in four, so the design sees stalls on some words.
  task automatic rd_rsp(input int last);
    int g;
    logic [31:0] r;
    logic [7:0]  t;
    t = (last == 14) ? `FCSR_RSP_PART_STATS : `FCSR_RSP_FC_LINK;
    for (int n = 4; n <= last; n++)
    begin
      g = 0;
      do
      begin
        @(negedge clk_i);
        r = nxt();
        rsp_ready_i = r[0] | r[1];
        g++;
      end
      while (!(rsp_valid_o === 1'h1 && rsp_ready_i) && g < 400);
      r = {26'h0, 1'h1, n == last, n[3:0]};
      chk({26'h0, rsp_valid_o, rsp_last_o, rsp_word_idx_o}, r);
      chk({24'h0, rsp_pkt_type_o}, {24'h0, t});
      chk(rsp_word_o, ew[n]);
    end
    @(negedge clk_i);
    rsp_ready_i = 1'h0;
  endtask

  task automatic traffic(input int n);
    logic [31:0] r;
    repeat (n)
    begin
      @(negedge clk_i);
      r = nxt();
      ev = r[6:0] & r[13:7];
      for (int i = 0; i < 6; i++)
        cnt[i] += ev[i];
      cnt[8] += ev[6];
    end
    @(negedge clk_i);
    ev = 7'h00;
  endtask

  task automatic pulse(input int p);
    @(negedge clk_i);
    pin[p] = 1'h1;
    repeat (6) @(negedge clk_i);
    pin[p] = 1'h0;
    repeat (6) @(negedge clk_i);
    cnt[6 + p]++;
  endtask

  task automatic clear_some();
    logic [31:0] r;
    r = nxt();
    @(negedge clk_i);
    ctr_clr_i = r[8:0];
    for (int i = 0; i < 9; i++)
      if (r[i])
      begin
        cnt[i] = 32'h0;
        flg[i] = 1'h1;
      end
    @(negedge clk_i);
    ctr_clr_i = 9'h000;
  endtask

  task automatic stats_query();
    send_cmd(`FCSR_CMD_PART_STATS, `FCSR_STATS_TYPE_FC, 1'h0, 1'h0);
    ew[4] = 32'h0;
    ew[5] = {23'h0, flg};
    for (int i = 0; i < 9; i++)
      ew[6 + i] = cnt[i];
    flg = 9'h000;
    rd_rsp(14);
  endtask

  task automatic drop_case(input logic [7:0] c, input logic [7:0] t, input logic e1, input logic e2);
    logic d;
    logic v;
    d = 1'h0;
    v = 1'h0;
    send_cmd(c, t, e1, e2);
    repeat (4)
    begin
      d |= cmd_drop_o;
      v |= rsp_valid_o | phy_rd_o;
      @(negedge clk_i);
    end
    chk({30'h0, d, v}, 32'h2);
  endtask

  task automatic link_case(input logic f, input logic m, input logic [2:0] s, input logic [1:0] d);
    logic [31:0] r;
    r = nxt();
    {p_fail, p_mute, p_up, p_spd, drv_state_i, p_dly} = {f, m, r[8], s, d, 3'h0, r[4:0]};
    send_cmd(`FCSR_CMD_FC_LINK, r[23:16], 1'h0, 1'h0);
    ew[4] = (f | m) ? {`FCSR_RSP_CODE_FAIL, `FCSR_RSN_PHY_ACCESS} : 32'h0;
    ew[5] = (f | m) ? 32'h0 : link_w(r[8], s, d);
    rd_rsp(5);
  endtask

  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      complete_run();
    end
  end

  initial
  begin
    for (k = 0; k < 9; k++)
      cnt[k] = 32'h0;
    repeat (20) @(posedge clk_i);
    @(negedge clk_i);
    rst_b_i = 1'h1;
    for (k = 0; k < 4; k++)
    begin
      traffic(40);
      pulse(0);
      pulse(1);
      if (k == 1 || k == 2)
        clear_some();
      stats_query();
      $display("stats test %0d finished", k);
    end
    drop_case(`FCSR_CMD_PART_STATS, `FCSR_STATS_TYPE_FC, 1'h1, 1'h0);
    drop_case(`FCSR_CMD_PART_STATS, `FCSR_STATS_TYPE_FC, 1'h0, 1'h1);
    drop_case(`FCSR_CMD_PART_STATS, 8'h01, 1'h0, 1'h0);
    drop_case(`FCSR_CMD_FC_LINK, 8'h00, 1'h1, 1'h0);
    drop_case(8'h50, 8'h00, 1'h0, 1'h0);
    cfg_fc_native_i = 1'h0;
    drop_case(`FCSR_CMD_FC_LINK, 8'h00, 1'h0, 1'h0);
    cfg_fc_native_i = 1'h1;
    $display("drop test finished");
    for (k = 0; k < 8; k++)
      link_case(1'h0, 1'h0, k[2:0], k[1:0]);
    link_case(1'h1, 1'h0, 3'h5, 2'h2);
    link_case(1'h0, 1'h1, 3'h3, 2'h1);
    $display("link test finished");
    complete_run();
  end
endmodule
